// ---- verilog/interrupt_priority_fields.sv ----
`timescale 1ns/1ps
module interrupt_priority_fields
	import prio_fields_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [prio_fields_pkg::ADDR_W-1:0] addr,
	input wire logic [prio_fields_pkg::DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [prio_fields_pkg::DATA_W-1:0] rdata_r,
	// interrupt flags of the sources, index order as in the package
	input wire logic [prio_fields_pkg::NUM_SRC-1:0] src_flag,
	// per-source level and gated request toward the arbiter
	output logic [prio_fields_pkg::NUM_SRC*prio_fields_pkg::PRIO_W-1:0] src_level,
	output logic [prio_fields_pkg::NUM_SRC-1:0] src_req
);
	import prio_fields_pkg::*;

	// ***********************************
	// field storage
	// ***********************************
	logic [NUM_SRC-1:0] field_wr;
	logic [NUM_SRC*PRIO_W-1:0] field_wdata;
	logic [PRIO_W-1:0] level [NUM_SRC];
	logic [DATA_W-1:0] rdata_nxt;

	always_comb
	begin
		field_wr = '0;
		field_wdata = '0;
		field_wr[SRC_CHANGE_NOTIFY] = wr_stb && (addr == ADDR_PRIO_FOUR);
		field_wr[SRC_COMPARATOR] = wr_stb && (addr == ADDR_PRIO_FOUR);
		field_wr[SRC_SERIAL_MASTER] = wr_stb && (addr == ADDR_PRIO_FOUR);
		field_wr[SRC_SERIAL_SLAVE] = wr_stb && (addr == ADDR_PRIO_FOUR);
		field_wr[SRC_EXT_IRQ1] = wr_stb && (addr == ADDR_PRIO_FIVE);
		field_wdata[SRC_CHANGE_NOTIFY*PRIO_W +: PRIO_W] = wdata[CHANGE_NOTIFY_LSB +: PRIO_W];
		field_wdata[SRC_COMPARATOR*PRIO_W +: PRIO_W] = wdata[COMPARATOR_LSB +: PRIO_W];
		field_wdata[SRC_SERIAL_MASTER*PRIO_W +: PRIO_W] = wdata[SERIAL_MASTER_LSB +: PRIO_W];
		field_wdata[SRC_SERIAL_SLAVE*PRIO_W +: PRIO_W] = wdata[SERIAL_SLAVE_LSB +: PRIO_W];
		field_wdata[SRC_EXT_IRQ1*PRIO_W +: PRIO_W] = wdata[EXT_IRQ1_LSB +: PRIO_W];
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++)
		begin : g_field
			prio_field u_field (
				.clk(clk),
				.arst_n(arst_n),
				.wr_en(field_wr[gi]),
				.wr_data(field_wdata[gi*PRIO_W +: PRIO_W]),
				.flag(src_flag[gi]),
				.level_r(level[gi]),
				.req_r(src_req[gi])
			);
			assign src_level[gi*PRIO_W +: PRIO_W] = level[gi];
		end
	endgenerate

	// ***********************************
	// read path
	// ***********************************
	// unimplemented bits are never stored, so they read zero without masking
	always_comb
	begin
		rdata_nxt = DATA_ZERO;
		if (rd_stb)
		begin
			unique case (addr)
				ADDR_PRIO_FOUR:
				begin
					rdata_nxt[CHANGE_NOTIFY_LSB +: PRIO_W] = level[SRC_CHANGE_NOTIFY];
					rdata_nxt[COMPARATOR_LSB +: PRIO_W] = level[SRC_COMPARATOR];
					rdata_nxt[SERIAL_MASTER_LSB +: PRIO_W] = level[SRC_SERIAL_MASTER];
					rdata_nxt[SERIAL_SLAVE_LSB +: PRIO_W] = level[SRC_SERIAL_SLAVE];
				end
				ADDR_PRIO_FIVE:
					rdata_nxt[EXT_IRQ1_LSB +: PRIO_W] = level[SRC_EXT_IRQ1];
				ADDR_LEVELS:
					rdata_nxt[NUM_SRC-1:0] = src_req;
				default:
					rdata_nxt = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_r <= DATA_ZERO;
		else
			rdata_r <= rdata_nxt;
	end
endmodule // interrupt_priority_fields

// ---- verilog/prio_fields_pkg.sv ----
package prio_fields_pkg;
	// ***********************************
	// register map and field layout
	// ***********************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int PRIO_W = 3;
	localparam int NUM_SRC = 5;
	localparam logic [ADDR_W-1:0] ADDR_PRIO_FOUR = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_PRIO_FIVE = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_LEVELS = 4'h2;
	localparam int CHANGE_NOTIFY_LSB = 12;
	localparam int COMPARATOR_LSB = 8;
	localparam int SERIAL_MASTER_LSB = 4;
	localparam int SERIAL_SLAVE_LSB = 0;
	localparam int EXT_IRQ1_LSB = 0;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
	localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	// source index order in the level outputs
	localparam int SRC_CHANGE_NOTIFY = 0;
	localparam int SRC_COMPARATOR = 1;
	localparam int SRC_SERIAL_MASTER = 2;
	localparam int SRC_SERIAL_SLAVE = 3;
	localparam int SRC_EXT_IRQ1 = 4;
endpackage

// ---- verilog/prio_field.sv ----
`timescale 1ns/1ps
// one 3-bit priority setting with its request gating
module prio_field
	import prio_fields_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// write port
	input wire logic wr_en,
	input wire logic [PRIO_W-1:0] wr_data,
	// source
	input wire logic flag,
	// results
	output logic [PRIO_W-1:0] level_r,
	output logic req_r
);
	logic [PRIO_W-1:0] level_nxt;
	logic req_nxt;

	always_comb
	begin
		level_nxt = level_r;
		if (wr_en)
			level_nxt = wr_data;
		// code value is the level itself: 7 highest, 1 lowest
		// code 0 blocks the request whatever the flag says
		req_nxt = flag && (level_r != PRIO_DISABLED);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			level_r <= PRIO_RESET;
			req_r <= 1'h0;
		end
		else
		begin
			level_r <= level_nxt;
			req_r <= req_nxt;
		end
	end
endmodule // prio_field

// ---- testbench/prio_chk_assertions.sv ----
`timescale 1ns/1ps
module prio_chk(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [15:0] rdata_r,
	input wire logic [4:0] src_flag,
	input wire logic [14:0] src_level,
	input wire logic [4:0] src_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_GAP4: assert property (rd_stb && addr == 4'h0 |=> (rdata_r & 16'h8888) == 16'h0000) else $error("gap");
	AST_GAP5: assert property (rd_stb && addr == 4'h1 |=> rdata_r[15:3] == 13'h0000) else $error("gap5");
	AST_CMP: assert property (wr_stb && addr == 4'h0 |=> src_level[5:3] == $past(wdata[10:8])) else $error("cmp");
	AST_MST: assert property (wr_stb && addr == 4'h0 |=> src_level[8:6] == $past(wdata[6:4])) else $error("mst");
	AST_NTF: assert property (wr_stb && addr == 4'h0 |=> src_level[2:0] == $past(wdata[14:12])) else $error("ntf");
	AST_EXT: assert property (wr_stb && addr == 4'h1 |=> src_level[14:12] == $past(wdata[2:0])) else $error("ext");
	AST_OFF: assert property (src_level[2:0] == 3'h0 |=> !src_req[0]) else $error("off");
	AST_ON: assert property (src_flag[1] && src_level[5:3] != 3'h0 |=> src_req[1]) else $error("on");
endmodule // prio_chk
bind interrupt_priority_fields prio_chk i_chk(.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r), .src_flag(src_flag), .src_level(src_level), .src_req(src_req));

// ---- testbench/tb_interrupt_priority_fields.sv ----
`timescale 1ns/1ps
module tb_interrupt_priority_fields;
	logic clk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0;
	logic [3:0] addr = 0;
	logic [15:0] wdata = 0, rdata_r;
	logic [4:0] src_flag = 0, src_req;
	logic [14:0] src_level;
	int bad_count, checks, cyc;
	interrupt_priority_fields i_dut(.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata_r(rdata_r), .src_flag(src_flag), .src_level(src_level), .src_req(src_req));
	initial forever #20 clk = ~clk;
	task chk(string n, logic [15:0] e, logic [15:0] s);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
		@(posedge clk) wr_stb <= 0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(logic [3:0] a, logic [15:0] e);
		@(posedge clk) {addr, rd_stb} <= {a, 1'b1};
		@(posedge clk) rd_stb <= 0;
		#1 chk("rdata", e, rdata_r);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ***********************************
	// scenarios
	// ***********************************
	task t_map;
		#1 chk("level", 16'h4924, src_level);
		rd(0, 16'h4444);
		rd(1, 16'h0004);
		wr(0, 16'hFFFF);
		rd(0, 16'h7777);
		wr(0, 16'h7531);
		rd(0, 16'h7531);
		wr(1, 16'hFFFF);
		rd(1, 16'h0007);
		rd(15, 0);
		$display("map done");
	endtask
	task t_codes;
		@(posedge clk) src_flag <= 5'h1F;
		wr(0, 16'h0000);
		repeat (2) @(posedge clk);
		#1 chk("req", 0, src_req[3:0]);
		for (int c = 0; c < 8; c++)
		begin
			wr(1, c[15:0]);
			repeat (2) @(posedge clk);
			#1 chk("ext", {c != 0, c[2:0]}, {src_req[4], src_level[14:12]});
		end
		rd(2, 16'h0010);
		// the status index holds no field, so a write there must leave every level alone
		wr(2, 16'hFFFF);
		@(posedge clk);
		#1 chk("level", 16'h7000, src_level);
		$display("codes done");
	endtask
	task t_reset;
		@(posedge clk) arst_n <= 0;
		repeat (2) @(posedge clk);
		arst_n <= 1;
		#1 chk("level", 16'h4924, src_level);
		@(posedge clk);
		#1 chk("req", 16'h001F, src_req);
		rd(0, 16'h4444);
		$display("reset done");
	endtask
	always @(posedge clk)
		if (++cyc == 2000)
		begin
			bad_count++;
			give_verdict;
		end
	initial
	begin
		repeat (8) @(posedge clk);
		arst_n <= 1;
		t_map;
		t_codes;
		t_reset;
		give_verdict;
	end
endmodule // tb_interrupt_priority_fields
